// ### logic/bsacs_alu_end.sv
`timescale 1ns/1ps
`default_nettype none
module bsacs_alu_end #(
  parameter int WORD_W = bsacs_pkg::WORD_W,
  parameter int BYTE_W = bsacs_pkg::BYTE_W,
  parameter int LANES  = bsacs_pkg::LANES
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rstn_in,
  bsacs_link_if.alu             link,
  output logic      [LANES-1:0] bcd_flags_out
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] y;
    logic              zero;
    logic              neg;
    logic              ovf;
    logic              carry;
    logic [WORD_W-1:0] quo;
    logic [LANES-1:0]  bcd;
  } bsacs_alu_st_t;

  bsacs_alu_st_t q_reg;
  bsacs_alu_st_t q_next;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_clear(input logic [7:0] op);
    logic hit;
    hit = (op == bsacs_pkg::OP_CLEAR);
    for (int i = 0; i < $size(bsacs_pkg::CLR_ALT); i++)
    begin
      if (op == bsacs_pkg::CLR_ALT[i])
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [1:0] top_lane(input logic [LANES-1:0] sel);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 0; i < LANES; i++)
    begin
      if (sel[i])
      begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // ****************************************
  // byte lanes
  // ****************************************
  logic [LANES-1:0]  sel;
  logic [LANES:0]    lane_c;
  logic [LANES-1:0]  lane_ovf;
  logic [WORD_W-1:0] lane_f;
  logic              is_sub;

  assign sel       = ~link.byte_select_n;
  assign is_sub    = (link.opcode == bsacs_pkg::OP_SUB_RS);
  assign lane_c[0] = is_sub & link.carry_in;

  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : gen_lane
      bsacs_byte_lane #(
        .W (BYTE_W)
      ) u_lane (
        .r_in      (link.r_bus[g*BYTE_W +: BYTE_W]),
        .s_in      (link.s_bus[g*BYTE_W +: BYTE_W]),
        .sel_in    (sel[g]),
        .sub_in    (is_sub),
        .carry_in  (lane_c[g]),
        .f_out     (lane_f[g*BYTE_W +: BYTE_W]),
        .carry_out (lane_c[g+1]),
        .ovf_out   (lane_ovf[g])
      );
    end
  endgenerate

  // ****************************************
  // selected-byte status
  // ****************************************
  logic [1:0] top_idx;
  logic       sel_zero;
  logic       top_sign;
  logic       top_ovf;
  logic       top_carry;

  always_comb
  begin
    top_idx  = top_lane(sel);
    sel_zero = 1'b1;
    for (int i = 0; i < LANES; i++)
    begin
      if (sel[i] && (lane_f[i*BYTE_W +: BYTE_W] != '0))
      begin
        sel_zero = 1'b0;
      end
    end
    top_sign  = lane_f[int'(top_idx)*BYTE_W + BYTE_W - 1];
    top_ovf   = lane_ovf[top_idx];
    top_carry = lane_c[int'(top_idx) + 1];
  end

  // ****************************************
  // crc step
  // ****************************************
  logic              crc_fb;
  logic [WORD_W-1:0] crc_shf;
  logic [WORD_W-1:0] crc_y;

  always_comb
  begin
    crc_fb  = q_reg.quo[0] ^ link.s_bus[0];
    crc_shf = crc_fb ? (link.r_bus ^ link.s_bus) : link.s_bus;
    crc_y   = {link.r_bus[0] & crc_fb, crc_shf[WORD_W-1:1]};
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    q_next       = q_reg;
    q_next.valid = 1'b0;
    if (link.op_valid)
    begin
      q_next.valid = 1'b1;
      q_next.neg   = 1'b0;
      q_next.ovf   = 1'b0;
      q_next.carry = 1'b0;
      if (is_clear(link.opcode))
      begin
        q_next.y    = '0;
        q_next.bcd  = '0;
        q_next.zero = 1'b1;
      end
      else
      begin
        case (link.opcode)
          bsacs_pkg::OP_SUB_RS:
          begin
            q_next.y     = lane_f;
            q_next.zero  = sel_zero;
            q_next.neg   = top_sign;
            q_next.ovf   = top_ovf;
            q_next.carry = top_carry;
          end
          bsacs_pkg::OP_XOR:
          begin
            q_next.y    = lane_f;
            q_next.zero = sel_zero;
          end
          bsacs_pkg::OP_CRC:
          begin
            q_next.y    = crc_y;
            q_next.zero = (crc_y == '0);
            q_next.quo  = {q_reg.quo[0], q_reg.quo[WORD_W-1:1]};
          end
          bsacs_pkg::OP_LOADMQ:
          begin
            q_next.quo  = link.s_bus;
            q_next.y    = link.s_bus;
            q_next.zero = (link.s_bus == '0);
          end
          default:
          begin
            q_next.y    = link.s_bus;
            q_next.zero = (link.s_bus == '0);
          end
        endcase
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      q_reg <= '0;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.result_valid                 = q_reg.valid;
  assign link.y                            = q_reg.y;
  assign link.zero_flag                    = q_reg.zero;
  assign link.negative_flag                = q_reg.neg;
  assign link.overflow_flag                = q_reg.ovf;
  assign link.carry_flag                   = q_reg.carry;
  assign link.multiplier_quotient_register = q_reg.quo;
  assign bcd_flags_out                     = q_reg.bcd;
endmodule // bsacs_alu_end
`default_nettype wire

// ### logic/bsacs_byte_lane.sv
`timescale 1ns/1ps
`default_nettype none
module bsacs_byte_lane #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] r_in,
  input  wire logic [W-1:0] s_in,
  input  wire logic         sel_in,
  input  wire logic         sub_in,
  input  wire logic         carry_in,
  output logic      [W-1:0] f_out,
  output logic              carry_out,
  output logic              ovf_out
);
  logic [W:0] sum;
  always_comb
  begin
    sum = {1'b0, r_in} + {1'b0, ~s_in} + {{W{1'b0}}, carry_in};
    f_out     = s_in;
    carry_out = carry_in;
    ovf_out   = 1'b0;
    if (sel_in)
    begin
      if (sub_in)
      begin
        f_out     = sum[W-1:0];
        carry_out = sum[W];
        ovf_out   = (r_in[W-1] ^ s_in[W-1]) & (sum[W-1] ^ r_in[W-1]);
      end
      else
      begin
        f_out = r_in ^ s_in;
      end
    end
  end
endmodule // bsacs_byte_lane
`default_nettype wire

// ### logic/bsacs_seq_end.sv
`timescale 1ns/1ps
`default_nettype none
module bsacs_seq_end (
  input  wire logic                           ref_clk_in,
  input  wire logic                           rstn_in,
  input  wire logic [bsacs_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [bsacs_pkg::WORD_W-1:0]   wdata_in,
  input  wire logic                           wr_in,
  input  wire logic                           rd_in,
  output logic      [bsacs_pkg::WORD_W-1:0]   rdata_out,
  output logic                                irq_out,
  bsacs_link_if.seq                           link
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    bsacs_pkg::bsacs_state_t         st;
    bsacs_pkg::bsacs_kind_t          kind;
    logic [5:0]                      cnt;
    logic [bsacs_pkg::WORD_W-1:0]    gen;
    logic [bsacs_pkg::WORD_W-1:0]    acc;
    logic [bsacs_pkg::WORD_W-1:0]    man_r;
    logic [bsacs_pkg::WORD_W-1:0]    man_s;
    logic [bsacs_pkg::CFG_W-1:0]     man_cfg;
    logic [bsacs_pkg::WORD_W-1:0]    result;
    logic [bsacs_pkg::FLG_W-1:0]     flags;
    logic [bsacs_pkg::IRQ_W-1:0]     stat;
    logic [bsacs_pkg::IRQ_W-1:0]     mask;
    logic [bsacs_pkg::WORD_W-1:0]    rdata;
    logic                            irq;
    logic                            op_valid;
    logic [7:0]                      opcode;
    logic [bsacs_pkg::WORD_W-1:0]    r_bus;
    logic [bsacs_pkg::WORD_W-1:0]    s_bus;
    logic                            cin;
    logic [3:0]                      bsel_n;
  } bsacs_seq_st_t;

  bsacs_seq_st_t q_reg;
  bsacs_seq_st_t q_next;

  // adjacent selection with at least one byte left out
  function automatic logic sel_legal(input logic [3:0] sel_n);
    logic [3:0] s;
    s = ~sel_n;
    return (s != 4'hf) && (s != 4'h0) && (s != 4'h5) && (s != 4'h9) &&
           (s != 4'ha) && (s != 4'hb) && (s != 4'hd);
  endfunction

  logic [bsacs_pkg::IRQ_W-1:0] set_ev;
  logic [bsacs_pkg::IRQ_W-1:0] clr_ev;
  logic                        idle;
  logic [7:0]                  man_op;
  logic                        byte_op;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    q_next          = q_reg;
    q_next.op_valid = 1'b0;
    q_next.rdata    = '0;
    set_ev          = '0;
    clr_ev          = '0;
    idle            = (q_reg.st == bsacs_pkg::ST_IDLE);
    man_op          = q_reg.man_cfg[7:0];
    byte_op         = (man_op == bsacs_pkg::OP_SUB_RS) || (man_op == bsacs_pkg::OP_XOR);
    if (rd_in)
    begin
      case (addr_in)
        bsacs_pkg::REG_CTRL:     q_next.rdata = {31'h0, ~idle};
        bsacs_pkg::REG_GEN:      q_next.rdata = q_reg.gen;
        bsacs_pkg::REG_ACC:      q_next.rdata = q_reg.acc;
        bsacs_pkg::REG_MAN_R:    q_next.rdata = q_reg.man_r;
        bsacs_pkg::REG_MAN_S:    q_next.rdata = q_reg.man_s;
        bsacs_pkg::REG_MAN_CFG:  q_next.rdata = {19'h0, q_reg.man_cfg};
        bsacs_pkg::REG_RESULT:   q_next.rdata = q_reg.result;
        bsacs_pkg::REG_FLAGS:    q_next.rdata = {28'h0, q_reg.flags};
        bsacs_pkg::REG_IRQ_STAT: q_next.rdata = {29'h0, q_reg.stat};
        bsacs_pkg::REG_IRQ_MASK: q_next.rdata = {29'h0, q_reg.mask};
        default:                 q_next.rdata = '0;
      endcase
    end
    if (wr_in)
    begin
      case (addr_in)
        bsacs_pkg::REG_GEN:      q_next.gen = wdata_in;
        bsacs_pkg::REG_MAN_R:    q_next.man_r = wdata_in;
        bsacs_pkg::REG_MAN_S:    q_next.man_s = wdata_in;
        bsacs_pkg::REG_MAN_CFG:  q_next.man_cfg = wdata_in[bsacs_pkg::CFG_W-1:0];
        bsacs_pkg::REG_IRQ_MASK: q_next.mask = wdata_in[bsacs_pkg::IRQ_W-1:0];
        bsacs_pkg::REG_IRQ_STAT: clr_ev = wdata_in[bsacs_pkg::IRQ_W-1:0];
        bsacs_pkg::REG_MSG:
        begin
          if (idle)
          begin
            q_next.st       = bsacs_pkg::ST_WAIT;
            q_next.kind     = bsacs_pkg::K_LOAD;
            q_next.op_valid = 1'b1;
            q_next.opcode   = bsacs_pkg::OP_LOADMQ;
            q_next.s_bus    = wdata_in;
            q_next.bsel_n   = bsacs_pkg::SEL_NONE;
            q_next.cin      = 1'b0;
          end
        end
        bsacs_pkg::REG_CTRL:
        begin
          if (idle && wdata_in[bsacs_pkg::CTRL_CLR_ACC])
          begin
            q_next.st       = bsacs_pkg::ST_WAIT;
            q_next.kind     = bsacs_pkg::K_CLR;
            q_next.op_valid = 1'b1;
            q_next.opcode   = bsacs_pkg::OP_CLEAR;
            q_next.bsel_n   = bsacs_pkg::SEL_NONE;
            q_next.cin      = 1'b0;
          end
          else if (idle && wdata_in[bsacs_pkg::CTRL_MAN_GO])
          begin
            if (byte_op && !sel_legal(q_reg.man_cfg[bsacs_pkg::CFG_SEL_LSB +: 4]))
            begin
              set_ev[bsacs_pkg::IRQ_ERR] = 1'b1;
            end
            else
            begin
              q_next.st       = bsacs_pkg::ST_WAIT;
              q_next.kind     = bsacs_pkg::K_MAN;
              q_next.op_valid = 1'b1;
              q_next.opcode   = man_op;
              q_next.r_bus    = q_reg.man_r;
              q_next.s_bus    = q_reg.man_s;
              q_next.bsel_n   = q_reg.man_cfg[bsacs_pkg::CFG_SEL_LSB +: 4];
              q_next.cin      = q_reg.man_cfg[bsacs_pkg::CFG_CIN_BIT];
            end
          end
        end
        default:
        begin
        end
      endcase
    end
    if (!idle && link.result_valid)
    begin
      q_next.flags = {link.carry_flag, link.overflow_flag, link.negative_flag,
                      link.zero_flag};
      q_next.st    = bsacs_pkg::ST_IDLE;
      case (q_reg.kind)
        bsacs_pkg::K_LOAD, bsacs_pkg::K_CRC:
        begin
          if (q_reg.kind == bsacs_pkg::K_CRC)
          begin
            q_next.acc = link.y;
            q_next.cnt = q_reg.cnt + 6'h01;
          end
          else
          begin
            q_next.cnt = '0;
          end
          if (q_reg.kind == bsacs_pkg::K_CRC && q_reg.cnt == bsacs_pkg::LAST_STEP)
          begin
            set_ev[bsacs_pkg::IRQ_CRC] = 1'b1;
          end
          else
          begin
            q_next.st       = bsacs_pkg::ST_WAIT;
            q_next.kind     = bsacs_pkg::K_CRC;
            q_next.op_valid = 1'b1;
            q_next.opcode   = bsacs_pkg::OP_CRC;
            q_next.r_bus    = q_reg.gen;
            q_next.s_bus    = (q_reg.kind == bsacs_pkg::K_CRC) ? link.y : q_reg.acc;
          end
        end
        bsacs_pkg::K_CLR:
        begin
          q_next.acc = link.y;
        end
        default:
        begin
          q_next.result             = link.y;
          set_ev[bsacs_pkg::IRQ_MAN] = 1'b1;
        end
      endcase
    end
    q_next.stat = (q_reg.stat & ~clr_ev) | set_ev;
    q_next.irq  = |(q_next.stat & q_next.mask);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      q_reg         <= '0;
      q_reg.bsel_n  <= bsacs_pkg::SEL_NONE;
      q_reg.man_cfg <= bsacs_pkg::CFG_RESET;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign rdata_out          = q_reg.rdata;
  assign irq_out            = q_reg.irq;
  assign link.op_valid      = q_reg.op_valid;
  assign link.opcode        = q_reg.opcode;
  assign link.r_bus         = q_reg.r_bus;
  assign link.s_bus         = q_reg.s_bus;
  assign link.carry_in      = q_reg.cin;
  assign link.byte_select_n = q_reg.bsel_n;
endmodule // bsacs_seq_end
`default_nettype wire

// ### pkg/bsacs_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bsacs_link_if;
  logic        op_valid;
  logic [7:0]  opcode;
  logic [31:0] r_bus;
  logic [31:0] s_bus;
  logic        carry_in;
  logic [3:0]  byte_select_n;
  logic        result_valid;
  logic [31:0] y;
  logic        zero_flag;
  logic        negative_flag;
  logic        overflow_flag;
  logic        carry_flag;
  logic [31:0] multiplier_quotient_register;
  modport alu (
    input  op_valid, opcode, r_bus, s_bus, carry_in, byte_select_n,
    output result_valid, y, zero_flag, negative_flag, overflow_flag, carry_flag,
    output multiplier_quotient_register
  );
  modport seq (
    output op_valid, opcode, r_bus, s_bus, carry_in, byte_select_n,
    input  result_valid, y, zero_flag, negative_flag, overflow_flag, carry_flag,
    input  multiplier_quotient_register
  );
endinterface
`default_nettype wire

// ### pkg/bsacs_pkg.sv
`default_nettype none
package bsacs_pkg;
  // ****************************************
  // datapath shape
  // ****************************************
  localparam int WORD_W = 32;
  localparam int BYTE_W = 8;
  localparam int LANES  = 4;
  localparam int ADDR_W = 6;
  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [7:0] OP_SUB_RS = 8'h98;
  localparam logic [7:0] OP_XOR    = 8'hd8;
  localparam logic [7:0] OP_CLEAR  = 8'h0f;
  localparam logic [7:0] OP_CRC    = 8'h7a;
  localparam logic [7:0] OP_LOADMQ = 8'h7b;
  localparam logic [7:0] CLR_ALT [7] = '{8'h2f, 8'h3f, 8'h4f, 8'h6f, 8'hbf, 8'hcf, 8'hef};
  localparam logic [3:0] SEL_NONE  = 4'hf;
  // ****************************************
  // sequencer register map
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_CTRL     = 6'h00;
  localparam logic [ADDR_W-1:0] REG_GEN      = 6'h04;
  localparam logic [ADDR_W-1:0] REG_MSG      = 6'h08;
  localparam logic [ADDR_W-1:0] REG_ACC      = 6'h0c;
  localparam logic [ADDR_W-1:0] REG_MAN_R    = 6'h10;
  localparam logic [ADDR_W-1:0] REG_MAN_S    = 6'h14;
  localparam logic [ADDR_W-1:0] REG_MAN_CFG  = 6'h18;
  localparam logic [ADDR_W-1:0] REG_RESULT   = 6'h1c;
  localparam logic [ADDR_W-1:0] REG_FLAGS    = 6'h20;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 6'h24;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 6'h28;
  localparam int CTRL_CLR_ACC = 0;
  localparam int CTRL_MAN_GO  = 1;
  localparam int CFG_SEL_LSB  = 8;
  localparam int CFG_CIN_BIT  = 12;
  localparam int CFG_W        = 13;
  localparam logic [CFG_W-1:0] CFG_RESET = 13'h0f00;
  localparam int FLG_W        = 4;
  localparam int IRQ_CRC      = 0;
  localparam int IRQ_MAN      = 1;
  localparam int IRQ_ERR      = 2;
  localparam int IRQ_W        = 3;
  localparam logic [5:0] LAST_STEP = 6'(WORD_W - 1);
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_WAIT = 1'b1} bsacs_state_t;
  typedef enum logic [1:0] {
    K_LOAD = 2'b00,
    K_CRC  = 2'b01,
    K_MAN  = 2'b10,
    K_CLR  = 2'b11
  } bsacs_kind_t;
endpackage
`default_nettype wire

// ### testbench/bsacs_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// link checker
// ****
module bsacs_link_checker (
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  input wire logic        op_valid,
  input wire logic [7:0]  opcode,
  input wire logic [31:0] r_bus,
  input wire logic [31:0] s_bus,
  input wire logic        carry_in,
  input wire logic [3:0]  byte_select_n,
  input wire logic        result_valid,
  input wire logic [31:0] y,
  input wire logic        zero_flag,
  input wire logic        negative_flag,
  input wire logic        overflow_flag,
  input wire logic        carry_flag,
  input wire logic [31:0] multiplier_quotient_register
);
  logic [31:0] keep;
  logic [31:0] rxs;
  logic [31:0] crc_y;
  logic [31:0] quo;
  logic [31:0] quo_rot;
  logic        fb;
  logic        bytewise;
  logic        is_xor;
  logic        is_crc;
  assign keep = {{8{byte_select_n[3]}}, {8{byte_select_n[2]}}, {8{byte_select_n[1]}},
                 {8{byte_select_n[0]}}};
  assign quo = multiplier_quotient_register;
  assign rxs = r_bus ^ s_bus;
  assign fb = quo[0] ^ s_bus[0];
  assign crc_y = {r_bus[0] & fb, fb ? rxs[31:1] : s_bus[31:1]};
  assign quo_rot = {quo[0], quo[31:1]};
  assign is_xor = op_valid && opcode == bsacs_pkg::OP_XOR;
  assign is_crc = op_valid && opcode == bsacs_pkg::OP_CRC;
  assign bytewise = is_xor || (op_valid && opcode == bsacs_pkg::OP_SUB_RS);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // ****
  // properties
  // ****
  answer_next_a: assert property (op_valid |=> result_valid)
    else $error("answer late");
  no_stray_a: assert property (result_valid |-> $past(op_valid))
    else $error("answer without request");
  legal_sel_a: assert property (bytewise |->
    byte_select_n inside {4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h9, 4'h3, 4'h8, 4'h1})
    else $error("bad select");
  pass_unsel_a: assert property (bytewise |=>
    ((y ^ $past(s_bus)) & $past(keep)) == 32'h0) else $error("unselected byte changed");
  xor_sel_a: assert property (is_xor |=>
    ((y ^ $past(rxs)) & ~$past(keep)) == 32'h0) else $error("xor byte wrong");
  xor_flags_a: assert property (is_xor |=>
    !negative_flag && !overflow_flag && !carry_flag) else $error("xor flags set");
  sel_zero_a: assert property (bytewise |=>
    zero_flag == ((y & ~$past(keep)) == 32'h0)) else $error("zero flag wrong");
  clear_out_a: assert property (op_valid && opcode inside
    {8'h0f, 8'h2f, 8'h3f, 8'h4f, 8'h6f, 8'hbf, 8'hcf, 8'hef} |=> y == 32'h0 && zero_flag &&
    !negative_flag && !overflow_flag && !carry_flag) else $error("clear wrong");
  crc_value_a: assert property (is_crc |=> y == $past(crc_y))
    else $error("crc value wrong");
  quo_rotate_a: assert property (is_crc |=> quo == $past(quo_rot))
    else $error("quotient not rotated");
endmodule // bsacs_link_checker
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// bench top
// ****
module tb;
  typedef struct packed {
    logic [7:0]  op;
    logic [31:0] r;
    logic [31:0] s;
    logic [3:0]  sel;
    logic        cin;
    logic [31:0] y;
    logic [4:0]  f;
  } bsacs_row_t;
  logic        ref_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [5:0]  addr_in = 6'h0;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic        irq_out;
  logic [3:0]  bcd_flags_out;
  logic [31:0] d;
  logic [31:0] acc;
  int          err_total = 0;
  int          n_tests = 0;
  logic [7:0]  clr [8] = '{8'h0f, 8'h2f, 8'h3f, 8'h4f, 8'h6f, 8'hbf, 8'hcf, 8'hef};
  logic [3:0]  bad [4] = '{4'hf, 4'h0, 4'ha, 4'h5};
  logic [31:0] msg [2] = '{32'h12345678, 32'hcafe0001};
  bsacs_row_t  rows [11] = '{
    '{8'h98, 32'h5288b8b8, 32'h143a9898, 4'h9, 1'b1, 32'h144e2098, 5'h1c},
    '{8'h98, 32'h5288b8b8, 32'h143a9898, 4'h9, 1'b0, 32'h144e1f98, 5'h1c},
    '{8'h98, 32'h80000000, 32'h01abcdef, 4'h7, 1'b1, 32'h7fabcdef, 5'h1c},
    '{8'h98, 32'h00000055, 32'h12345655, 4'he, 1'b1, 32'h12345600, 5'h19},
    '{8'h98, 32'h00000001, 32'h00000002, 4'hc, 1'b1, 32'h0000ffff, 5'h12},
    '{8'hd8, 32'h578fbebe, 32'h1c90bebe, 4'h9, 1'b1, 32'h1c1f00be, 5'h10},
    '{8'hd8, 32'h000000aa, 32'hffffffaa, 4'he, 1'b0, 32'hffffff00, 5'h11},
    '{8'h7b, 32'h0, 32'h00000003, 4'hf, 1'b0, 32'h00000003, 5'h00},
    '{8'h7a, 32'hd, 32'h0, 4'hf, 1'b0, 32'h80000006, 5'h10},
    '{8'h7a, 32'hd, 32'h80000006, 4'hf, 1'b0, 32'hc0000005, 5'h10},
    '{8'h55, 32'h1, 32'h0000005a, 4'h0, 1'b1, 32'h0000005a, 5'h10}};
  bsacs_link_if link ();
  bsacs_alu_end bsacs_alu_end_inst (.ref_clk_in, .rstn_in, .link, .bcd_flags_out);
  bsacs_seq_end bsacs_seq_end_inst (.ref_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .irq_out, .link);
  bsacs_link_checker bsacs_link_checker_inst (.ref_clk_in, .rstn_in,
    .op_valid(link.op_valid), .opcode(link.opcode), .r_bus(link.r_bus), .s_bus(link.s_bus),
    .carry_in(link.carry_in), .byte_select_n(link.byte_select_n),
    .result_valid(link.result_valid), .y(link.y), .zero_flag(link.zero_flag),
    .negative_flag(link.negative_flag), .overflow_flag(link.overflow_flag),
    .carry_flag(link.carry_flag),
    .multiplier_quotient_register(link.multiplier_quotient_register));
  always #10 ref_clk_in = ~ref_clk_in;
  // ****
  // tasks
  // ****
  task automatic results();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic wait_irq(input logic [2:0] st);
    int i;
    for (i = 0; i < 2000 && irq_out !== 1'b1; i++)
      @(posedge ref_clk_in) #1;
    if (i == 2000)
    begin
      err_total++;
      results();
    end
    rd(bsacs_pkg::REG_IRQ_STAT);
    chk(d, 32'(st));
    wr(bsacs_pkg::REG_IRQ_STAT, d);
    repeat (2) @(posedge ref_clk_in);
  endtask
  task automatic run_op(input bsacs_row_t t, input logic [2:0] st);
    wr(bsacs_pkg::REG_MAN_R, t.r);
    wr(bsacs_pkg::REG_MAN_S, t.s);
    wr(bsacs_pkg::REG_MAN_CFG, {19'h0, t.cin, t.sel, t.op});
    wr(bsacs_pkg::REG_CTRL, 32'h2);
    wait_irq(st);
  endtask
  function automatic logic [31:0] crc_model(input logic [31:0] a, input logic [31:0] p,
                                            input logic [31:0] m);
    logic [31:0] sh;
    for (int i = 0; i < 32; i++)
    begin
      sh = (m[0] ^ a[0]) ? p ^ a : a;
      a = {p[0] & (m[0] ^ a[0]), sh[31:1]};
      m = {m[0], m[31:1]};
    end
    return a;
  endfunction
  // ****
  // sequence
  // ****
  initial
  begin
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    wr(bsacs_pkg::REG_IRQ_MASK, 32'h7);
    foreach (rows[i])
    begin
      run_op(rows[i], 3'h2);
      rd(bsacs_pkg::REG_RESULT);
      chk(d, rows[i].y);
      rd(bsacs_pkg::REG_FLAGS);
      if (rows[i].f[4])
        chk(d, 32'(rows[i].f[3:0]));
    end
    foreach (clr[i])
    begin
      run_op('{bsacs_pkg::OP_LOADMQ, 32'h0, 32'h5, 4'hf, 1'b0, 32'h0, 5'h0}, 3'h2);
      run_op('{clr[i], 32'h0, 32'h5, 4'hf, 1'b0, 32'h0, 5'h0}, 3'h2);
      rd(bsacs_pkg::REG_RESULT);
      chk(d, 32'h0);
      rd(bsacs_pkg::REG_FLAGS);
      chk(d, 32'h1);
      chk(32'(bcd_flags_out), 32'h0);
    end
    wr(bsacs_pkg::REG_IRQ_MASK, 32'h0);
    wr(bsacs_pkg::REG_CTRL, 32'h2);
    repeat (8) @(posedge ref_clk_in);
    #1 chk(32'(irq_out), 32'h0);
    rd(bsacs_pkg::REG_IRQ_STAT);
    chk(d, 32'h2);
    wr(bsacs_pkg::REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge ref_clk_in);
    #1 chk(32'(irq_out), 32'h1);
    wr(bsacs_pkg::REG_IRQ_STAT, 32'h2);
    repeat (2) @(posedge ref_clk_in);
    #1 chk(32'(irq_out), 32'h0);
    wr(bsacs_pkg::REG_IRQ_MASK, 32'h7);
    foreach (bad[i])
      run_op('{i[0] ? 8'hd8 : 8'h98, 32'h1, 32'h2, bad[i], 1'b1, 32'h0, 5'h0}, 3'h4);
    wr(bsacs_pkg::REG_GEN, 32'h04c11db6);
    wr(bsacs_pkg::REG_CTRL, 32'h1);
    repeat (6) @(posedge ref_clk_in);
    wr(bsacs_pkg::REG_IRQ_STAT, 32'h7);
    rd(bsacs_pkg::REG_ACC);
    chk(d, 32'h0);
    acc = 32'h0;
    foreach (msg[i])
    begin
      wr(bsacs_pkg::REG_MSG, msg[i]);
      rd(bsacs_pkg::REG_CTRL);
      chk(d & 32'h1, 32'h1);
      wr(bsacs_pkg::REG_MSG, 32'hffffffff);
      wait_irq(3'h1);
      acc = crc_model(acc, 32'h04c11db6, msg[i]);
      rd(bsacs_pkg::REG_ACC);
      chk(d, acc);
    end
    wr(bsacs_pkg::REG_ACC, 32'h0);
    rd(bsacs_pkg::REG_ACC);
    chk(d, acc);
    wr(bsacs_pkg::REG_CTRL, 32'h1);
    repeat (6) @(posedge ref_clk_in);
    rd(bsacs_pkg::REG_ACC);
    chk(d, 32'h0);
    run_op(rows[0], 3'h2);
    wr(6'h3c, 32'h1);
    rd(6'h3c);
    chk(d, 32'h0);
    @(posedge ref_clk_in) #1 chk(rdata_out, 32'h0);
    @(posedge ref_clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    chk(32'(link.byte_select_n), 32'hf);
    chk(link.y, 32'h0);
    rstn_in <= 1'b1;
    rd(bsacs_pkg::REG_MAN_CFG);
    chk(d, 32'(bsacs_pkg::CFG_RESET));
    results();
  end
endmodule // tb
`default_nettype wire
